// file: dac_cfg_pkg.sv
package dac_cfg_pkg;
	// ***************************************************
	// register addresses (5-bit memory map)
	// ***************************************************
	localparam logic [4:0] ADDR_REF_SEL_VOL = 5'h08;
	localparam logic [4:0] ADDR_PWRDN_VOL = 5'h09;
	localparam logic [4:0] ADDR_GAIN_STATUS = 5'h0a;
	localparam logic [4:0] ADDR_REF_SEL_NV = 5'h18;
	localparam logic [4:0] ADDR_PWRDN_NV = 5'h19;
	// ***************************************************
	// field positions and values after reset
	// ***************************************************
	localparam int GAIN_CH0_BIT = 8;
	localparam int POR_FLAG_BIT = 7;
	localparam int NVM_BUSY_BIT = 6;
	localparam logic [15:0] RST_REF_SEL = 16'h0000;
	localparam logic [15:0] RST_PWRDN = 16'h0000;
	localparam logic [1:0] RST_GAIN = 2'h0;
	// ***************************************************
	// reference select and power-down codes
	// ***************************************************
	localparam logic [1:0] REF_SUPPLY = 2'h0;
	localparam logic [1:0] REF_BANDGAP = 2'h1;
	localparam logic [1:0] REF_PIN_UNBUF = 2'h2;
	localparam logic [1:0] REF_PIN_BUF = 2'h3;
	localparam logic [1:0] PD_NORMAL = 2'h0;
	localparam logic [1:0] PD_1K = 2'h1;
	localparam logic [1:0] PD_100K = 2'h2;
	localparam logic [1:0] PD_OPEN = 2'h3;
endpackage

// file: dac_cfg_regs.sv
// Behaviour
// - ref code: 11 buf pin, 10 pin, 01 bandgap, 00 supply
// - bandgap ref keeps driving pin when powered down
// - pd code: 11 open, 10 100k, 01 1k
// - pd code 00 is normal operation
// - gain bits 8 and 9, 1 means 2x
// - supply reference forces 1x gain
// - bit 7 power-on flag, set by reset
// - power-on flag cleared by reading 0Ah
// - bit 6 busy during nvm load or write
// - only volatile commands accepted while busy
// - volatile-only variant: busy reads zero
// - unused upper bits read as zero
// - two power-down bits per channel
// - volatile and nonvolatile copies of ref, pd
// - load done after reset copies nonvolatile ref, pd into volatile
`timescale 1ns/1ns
module dac_cfg_regs #(
	parameter int NUM_CH = 2,
	parameter bit HAS_NVM = 1'b1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [4:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_nvm_busy,
	input wire logic i_load_done,
	output logic [15:0] o_rdata,
	output logic o_rd_valid,
	output logic o_accept,
	output logic [2*NUM_CH-1:0] o_ref_sel,
	output logic [2*NUM_CH-1:0] o_pwrdn,
	output logic [NUM_CH-1:0] o_gain_double,
	output logic [NUM_CH-1:0] o_ref_buf_en,
	output logic [NUM_CH-1:0] o_bandgap_en,
	output logic [NUM_CH-1:0] o_ref_pin_drive,
	output logic [NUM_CH-1:0] o_ch_powered_down,
	output logic [NUM_CH-1:0] o_load_1k,
	output logic [NUM_CH-1:0] o_load_100k
);
	localparam int W = 2 * NUM_CH;
	// ***************************************************
	// state
	// ***************************************************
	logic [W-1:0] ref_vol_ff, nxt_ref_vol;
	logic [W-1:0] pd_vol_ff, nxt_pd_vol;
	logic [W-1:0] ref_nv_ff, nxt_ref_nv;
	logic [W-1:0] pd_nv_ff, nxt_pd_nv;
	logic [NUM_CH-1:0] gain_ff, nxt_gain;
	logic por_flag_ff, nxt_por_flag;
	logic loaded_ff, nxt_loaded;
	logic [15:0] rdata_ff, nxt_rdata;
	logic rd_valid_ff, nxt_rd_valid;
	logic busy_s1_ff, busy_s2_ff;
	logic nvm_busy_flag;
	logic is_nv_addr;
	logic wr_take;
	logic rd_take;

	function automatic logic [15:0] zext(input logic [W-1:0] v);
		zext = 16'h0000;
		zext[W-1:0] = v;
	endfunction

	// gain and status word as the host reads it
	function automatic logic [15:0] status_word(
		input logic [NUM_CH-1:0] g,
		input logic por,
		input logic mb
	);
		status_word = 16'h0000;
		status_word[dac_cfg_pkg::GAIN_CH0_BIT +: NUM_CH] = g;
		status_word[dac_cfg_pkg::POR_FLAG_BIT] = por;
		status_word[dac_cfg_pkg::NVM_BUSY_BIT] = mb;
	endfunction

	// ***************************************************
	// reference and power-down code decoding
	// ***************************************************
	function automatic logic ref_buffered(input logic [1:0] code);
		ref_buffered = (code == dac_cfg_pkg::REF_PIN_BUF) ||
			(code == dac_cfg_pkg::REF_BANDGAP);
	endfunction

	function automatic logic ref_is_bandgap(input logic [1:0] code);
		ref_is_bandgap = (code == dac_cfg_pkg::REF_BANDGAP);
	endfunction

	// supply reference cannot take the doubled gain
	function automatic logic gain_applies(input logic [1:0] code);
		gain_applies = (code != dac_cfg_pkg::REF_SUPPLY);
	endfunction

	function automatic logic pd_active(input logic [1:0] code);
		pd_active = (code != dac_cfg_pkg::PD_NORMAL);
	endfunction

	// ***************************************************
	// busy synchroniser
	// ***************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_s1_ff <= 1'b0;
			busy_s2_ff <= 1'b0;
		end else if (i_ce) begin
			busy_s1_ff <= i_nvm_busy;
			busy_s2_ff <= busy_s1_ff;
		end
	end

	// busy during power-up load or external nvm write
	assign nvm_busy_flag = HAS_NVM && (!loaded_ff || busy_s2_ff);
	assign is_nv_addr = i_addr[4];
	assign o_accept = !(nvm_busy_flag && is_nv_addr);
	assign wr_take = i_wr && o_accept;
	assign rd_take = i_rd && o_accept;

	// ***************************************************
	// next state
	// ***************************************************
	always_comb begin
		nxt_ref_vol = ref_vol_ff;
		nxt_pd_vol = pd_vol_ff;
		nxt_ref_nv = ref_nv_ff;
		nxt_pd_nv = pd_nv_ff;
		nxt_gain = gain_ff;
		nxt_por_flag = por_flag_ff;
		nxt_loaded = loaded_ff;
		if (!loaded_ff && i_load_done) begin
			nxt_loaded = 1'b1;
			nxt_ref_vol = ref_nv_ff;
			nxt_pd_vol = pd_nv_ff;
		end
		if (wr_take) begin
			unique case (i_addr)
				dac_cfg_pkg::ADDR_REF_SEL_VOL: nxt_ref_vol = i_wdata[W-1:0];
				dac_cfg_pkg::ADDR_PWRDN_VOL: nxt_pd_vol = i_wdata[W-1:0];
				dac_cfg_pkg::ADDR_GAIN_STATUS: begin
					nxt_gain = i_wdata[dac_cfg_pkg::GAIN_CH0_BIT +: NUM_CH];
					if (!i_wdata[dac_cfg_pkg::POR_FLAG_BIT]) begin
						nxt_por_flag = 1'b0;
					end
				end
				dac_cfg_pkg::ADDR_REF_SEL_NV: begin
					if (HAS_NVM) begin
						nxt_ref_nv = i_wdata[W-1:0];
					end
				end
				dac_cfg_pkg::ADDR_PWRDN_NV: begin
					if (HAS_NVM) begin
						nxt_pd_nv = i_wdata[W-1:0];
					end
				end
				default: begin
				end
			endcase
		end
		if (rd_take && (i_addr == dac_cfg_pkg::ADDR_GAIN_STATUS)) begin
			nxt_por_flag = 1'b0;
		end
	end

	// ***************************************************
	// read path
	// ***************************************************
	always_comb begin
		nxt_rdata = rdata_ff;
		nxt_rd_valid = 1'b0;
		if (rd_take) begin
			nxt_rd_valid = 1'b1;
			unique case (i_addr)
				dac_cfg_pkg::ADDR_REF_SEL_VOL: nxt_rdata = zext(ref_vol_ff);
				dac_cfg_pkg::ADDR_PWRDN_VOL: nxt_rdata = zext(pd_vol_ff);
				dac_cfg_pkg::ADDR_GAIN_STATUS: begin
					nxt_rdata = status_word(gain_ff, por_flag_ff, nvm_busy_flag);
				end
				dac_cfg_pkg::ADDR_REF_SEL_NV: nxt_rdata = HAS_NVM ? zext(ref_nv_ff) : 16'h0000;
				dac_cfg_pkg::ADDR_PWRDN_NV: nxt_rdata = HAS_NVM ? zext(pd_nv_ff) : 16'h0000;
				default: nxt_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_ff <= 16'h0000;
			rd_valid_ff <= 1'b0;
		end else if (i_ce) begin
			rdata_ff <= nxt_rdata;
			rd_valid_ff <= nxt_rd_valid;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ref_vol_ff <= dac_cfg_pkg::RST_REF_SEL[W-1:0];
			pd_vol_ff <= dac_cfg_pkg::RST_PWRDN[W-1:0];
			ref_nv_ff <= dac_cfg_pkg::RST_REF_SEL[W-1:0];
			pd_nv_ff <= dac_cfg_pkg::RST_PWRDN[W-1:0];
			gain_ff <= dac_cfg_pkg::RST_GAIN[NUM_CH-1:0];
			por_flag_ff <= 1'b1;
			loaded_ff <= 1'b0;
		end else if (i_ce) begin
			ref_vol_ff <= nxt_ref_vol;
			pd_vol_ff <= nxt_pd_vol;
			ref_nv_ff <= nxt_ref_nv;
			pd_nv_ff <= nxt_pd_nv;
			gain_ff <= nxt_gain;
			por_flag_ff <= nxt_por_flag;
			loaded_ff <= nxt_loaded;
		end
	end

	// ***************************************************
	// analog controls
	// ***************************************************
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			o_ref_buf_en[c] = ref_buffered(ref_vol_ff[2*c +: 2]);
			o_bandgap_en[c] = ref_is_bandgap(ref_vol_ff[2*c +: 2]);
			o_ref_pin_drive[c] = ref_is_bandgap(ref_vol_ff[2*c +: 2]);
			o_gain_double[c] = gain_ff[c] && gain_applies(ref_vol_ff[2*c +: 2]);
			o_ch_powered_down[c] = pd_active(pd_vol_ff[2*c +: 2]);
			o_load_1k[c] = (pd_vol_ff[2*c +: 2] == dac_cfg_pkg::PD_1K);
			o_load_100k[c] = (pd_vol_ff[2*c +: 2] == dac_cfg_pkg::PD_100K);
		end
	end

	assign o_ref_sel = ref_vol_ff;
	assign o_pwrdn = pd_vol_ff;
	assign o_rdata = rdata_ff;
	assign o_rd_valid = rd_valid_ff;
endmodule

// file: dac_cfg_regs_props.sv
`timescale 1ns/1ns
module dac_cfg_regs_props #(parameter int NUM_CH = 2) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [4:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic [15:0] o_rdata,
	input wire logic o_rd_valid,
	input wire logic o_accept,
	input wire logic [2*NUM_CH-1:0] o_ref_sel,
	input wire logic [2*NUM_CH-1:0] o_pwrdn,
	input wire logic [NUM_CH-1:0] o_gain_double,
	input wire logic [NUM_CH-1:0] o_ref_buf_en,
	input wire logic [NUM_CH-1:0] o_bandgap_en,
	input wire logic [NUM_CH-1:0] o_ch_powered_down
);
	logic [2*NUM_CH-1:0] wr_low;
	logic gs_rd;
	logic pd_rd;
	assign wr_low = i_wdata[2*NUM_CH-1:0];
	assign gs_rd = i_ce && i_rd && (i_addr == 5'h0a);
	assign pd_rd = i_ce && i_rd && (i_addr == 5'h09);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	AST_BUF: assert property (o_ref_buf_en[0] == o_ref_sel[0])
		else $error("ref buffer wrong");
	AST_BG: assert property (o_ref_sel[1:0] == 2'h1 |-> o_bandgap_en[0])
		else $error("band gap off");
	AST_PD: assert property (o_ch_powered_down[0] == (o_pwrdn[1:0] != 2'h0))
		else $error("power-down wrong");
	AST_GN: assert property (o_ref_sel[1:0] == 2'h0 |-> !o_gain_double[0])
		else $error("gain not forced");
	AST_WR: assert property (i_ce && i_wr && i_addr == 5'h08 |=> o_ref_sel == $past(wr_low))
		else $error("ref write lost");
	AST_RF: assert property (i_ce && i_rd && !o_accept |=> !o_rd_valid)
		else $error("refused read answered");
	AST_POR: assert property (gs_rd && $past(gs_rd, 2) |=> !o_rdata[7])
		else $error("flag not cleared");
	AST_UP: assert property (o_rd_valid && $past(pd_rd) |-> o_rdata[15:2*NUM_CH] == '0)
		else $error("upper bits set");
endmodule
bind dac_cfg_regs dac_cfg_regs_props #(.NUM_CH(NUM_CH)) dac_cfg_regs_props_i (
	.i_clk(i_clk),
	.i_rst_n(i_rst_n),
	.i_ce(i_ce),
	.i_wr(i_wr),
	.i_rd(i_rd),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.o_rdata(o_rdata),
	.o_rd_valid(o_rd_valid),
	.o_accept(o_accept),
	.o_ref_sel(o_ref_sel),
	.o_pwrdn(o_pwrdn),
	.o_gain_double(o_gain_double),
	.o_ref_buf_en(o_ref_buf_en),
	.o_bandgap_en(o_bandgap_en),
	.o_ch_powered_down(o_ch_powered_down)
);

// file: dac_cfg_regs_tb_top.sv
`timescale 1ns/1ns
module dac_cfg_regs_tb_top;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_nvm_busy = 1'b0;
	logic i_load_done = 1'b0;
	logic i_ce = 1'b1;
	logic i_wr, i_rd, o_rd_valid, o_accept, v;
	logic [4:0] i_addr;
	logic [15:0] i_wdata, o_rdata, d;
	logic [3:0] o_ref_sel, o_pwrdn;
	logic [1:0] o_gain_double, o_ref_buf_en, o_bandgap_en, o_ref_pin_drive;
	logic [1:0] o_ch_powered_down, o_load_1k, o_load_100k;
	int failures = 0;
	int checked = 0;
	int cyc = 0;
	always #10 i_clk = ~i_clk;
	dac_cfg_regs dac_cfg_regs_i (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_nvm_busy(i_nvm_busy),
		.i_load_done(i_load_done),
		.o_rdata(o_rdata),
		.o_rd_valid(o_rd_valid),
		.o_accept(o_accept),
		.o_ref_sel(o_ref_sel),
		.o_pwrdn(o_pwrdn),
		.o_gain_double(o_gain_double),
		.o_ref_buf_en(o_ref_buf_en),
		.o_bandgap_en(o_bandgap_en),
		.o_ref_pin_drive(o_ref_pin_drive),
		.o_ch_powered_down(o_ch_powered_down),
		.o_load_1k(o_load_1k),
		.o_load_100k(o_load_100k)
	);
	host_model h (.i_clk(i_clk), .i_rd_valid(o_rd_valid), .i_rdata(o_rdata), .o_wr(i_wr),
		.o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic t_status();
		h.rd(5'h0a, v, d);
		chk(d, 16'h00c0);
		h.rd(5'h18, v, d);
		chk(v, 1'b0);
		h.rd(5'h0a, v, d);
		chk(d, 16'h0040);
		h.wr(5'h08, 16'h000f);
		chk(o_ref_sel, 4'hf);
		@(posedge i_clk);
		i_load_done <= 1'b1;
		@(posedge i_clk);
		i_load_done <= 1'b0;
		h.rd(5'h0a, v, d);
		chk(d, 16'h0000);
		chk(o_ref_sel, 4'h0);
		$display("status done");
	endtask
	task automatic t_ref();
		h.wr(5'h0a, 16'hffff);
		h.rd(5'h0a, v, d);
		h.rd(5'h0a, v, d);
		chk(d, 16'h0300);
		for (int c = 0; c < 4; c++) begin
			h.wr(5'h08, 16'hfff0 | 16'(c * 5));
			h.rd(5'h08, v, d);
			chk(d, 16'(c * 5));
			chk(o_ref_buf_en, {2{c[0]}});
			chk(o_bandgap_en, {2{c == 1}});
			chk(o_ref_pin_drive, {2{c == 1}});
			chk(o_gain_double, {2{c != 0}});
		end
		$display("ref done");
	endtask
	task automatic t_pd();
		h.wr(5'h08, 16'h0005);
		for (int p = 0; p < 4; p++) begin
			h.wr(5'h09, 16'hfff0 | 16'(p * 5));
			chk(o_ch_powered_down, {2{p != 0}});
			chk({o_load_1k, o_load_100k}, {{2{p == 1}}, {2{p == 2}}});
			chk(o_bandgap_en, 2'h3);
		end
		h.rd(5'h09, v, d);
		chk(d, 16'h000f);
		h.wr(5'h08, 16'h0000);
		chk(o_bandgap_en, 2'h0);
		$display("pd done");
	endtask
	task automatic t_nv();
		h.wr(5'h18, 16'h0006);
		h.rd(5'h18, v, d);
		chk(d, 16'h0006);
		@(posedge i_clk);
		i_nvm_busy <= 1'b1;
		repeat (3) @(posedge i_clk);
		h.wr(5'h19, 16'h0003);
		h.rd(5'h09, v, d);
		chk(v, 1'b1);
		h.rd(5'h19, v, d);
		chk(v, 1'b0);
		@(posedge i_clk);
		i_nvm_busy <= 1'b0;
		repeat (3) @(posedge i_clk);
		h.rd(5'h19, v, d);
		chk(d, 16'h0000);
		$display("nv done");
	endtask
	task automatic t_ce();
		@(posedge i_clk);
		i_ce <= 1'b0;
		h.wr(5'h08, 16'h000a);
		chk(o_ref_sel, 4'h0);
		@(posedge i_clk);
		i_ce <= 1'b1;
		$display("clock enable done");
	endtask
	task automatic t_bor();
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		chk(o_pwrdn, 4'h0);
		h.rd(5'h0a, v, d);
		chk(d, 16'h00c0);
		$display("brown-out done");
	endtask
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			summarize();
		end
	end
	initial begin
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		t_status();
		t_ref();
		t_pd();
		t_ce();
		t_nv();
		t_bor();
		summarize();
	end
endmodule

// file: host_model.sv
`timescale 1ns/1ns
module host_model (
	input wire logic i_clk,
	input wire logic i_rd_valid,
	input wire logic [15:0] i_rdata,
	output logic o_wr,
	output logic o_rd,
	output logic [4:0] o_addr,
	output logic [15:0] o_wdata
);
	initial {o_wr, o_rd, o_addr, o_wdata} = '0;
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_clk);
		{o_wr, o_addr, o_wdata} <= {1'b1, a, d};
		@(posedge i_clk);
		{o_wr, o_addr, o_wdata} <= {1'b0, ~a, ~d};
		#1;
	endtask
	task automatic rd(input logic [4:0] a, output logic v, output logic [15:0] d);
		@(posedge i_clk);
		{o_rd, o_addr} <= {1'b1, a};
		@(posedge i_clk);
		{o_rd, o_addr} <= {1'b0, ~a};
		#1;
		v = i_rd_valid;
		d = i_rdata;
	endtask
endmodule
